// File: rtl/sysreg_pkg.sv
// package: offsets, field layouts, reset values and carrier types of the system register block
package sysreg_pkg;

  // ---------------------------------------------------------------
  // register indices; byte address is the index times four
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CENTRAL_IRQ_CONTROL = 8'h00e6;
  localparam logic [7:0] IDX_CPU_STATUS_FLAGS = 8'h00e7;
  localparam logic [7:0] IDX_WORK_POINTER_LOW = 8'h00e8;
  localparam logic [7:0] IDX_WORK_POINTER_HIGH = 8'h00e9;
  localparam logic [7:0] IDX_NESTED_LEVEL_STORE = 8'h00f0;
  localparam logic [9:0] ADDR_CENTRAL_IRQ_CONTROL = {IDX_CENTRAL_IRQ_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_CPU_STATUS_FLAGS = {IDX_CPU_STATUS_FLAGS, 2'b00};
  localparam logic [9:0] ADDR_WORK_POINTER_LOW = {IDX_WORK_POINTER_LOW, 2'b00};
  localparam logic [9:0] ADDR_WORK_POINTER_HIGH = {IDX_WORK_POINTER_HIGH, 2'b00};
  localparam logic [9:0] ADDR_NESTED_LEVEL_STORE = {IDX_NESTED_LEVEL_STORE, 2'b00};

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CENTRAL_IRQ_CONTROL = 8'h0087;
  localparam logic [7:0] RST_CPU_STATUS_FLAGS = 8'h0000;
  localparam logic [7:0] RST_WORK_POINTER = 8'h0000;
  localparam logic [7:0] RST_NESTED_LEVEL_STORE = 8'h0000;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CIC_GATE = 7;
  localparam int CIC_TOP_PEND = 6;
  localparam int CIC_TOP_SEL = 5;
  localparam int CIC_GLOBAL_ON = 4;
  localparam int CIC_ARB = 3;
  localparam int FLG_CARRY = 7;
  localparam int FLG_ZERO = 6;
  localparam int FLG_SIGN = 5;
  localparam int FLG_OVF = 4;
  localparam int FLG_BCD = 3;
  localparam int FLG_HALF = 2;
  localparam int FLG_RSVD = 1;
  localparam int FLG_AREA = 0;
  localparam int PTR_MODE = 2;
  localparam int FLAG_STACK_DEPTH = 7;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CARRY_KEEP = 3'b001,
    CARRY_SET = 3'b010,
    CARRY_CPL = 3'b100
  } carry_op_t;

  // alu result presented by the execution unit, one-cycle strobe
  typedef struct packed {
    logic valid;
    logic word;
    logic [15:0] result;
    logic carry;
    logic half;
    logic overflow;
    logic is_sub;
    logic bcd_kind;
  } alu_update_t;

  // instruction strobes from the execution unit
  typedef struct packed {
    logic irq_ack;
    logic [2:0] ack_level;
    logic irq_return;
    logic ei;
    logic di;
    logic scf;
    logic rcf;
    logic ccf;
    logic sdm;
    logic spm;
    logic srp;
    logic set_twin_window_low;
    logic set_twin_window_high;
    logic [4:0] block;
  } cpu_cmd_t;

endpackage : sysreg_pkg

// File: rtl/sysreg_core.sv
// system registers: interrupt control, status flags, working-register pointers, AXI4-Lite slave
`timescale 1ns/1ns

// How it works
// [RQ1] interrupt control register resets to 87h: timer gate set, lowest priority
// [RQ2] timer counts only when gate bit and the timer's own enable are both set
// [RQ3] top pending bit set by hardware request or by software writing one
// [RQ4] mask select 0: top ack by mask bit only; 1: also needs global on
// [RQ5] global on cleared by ack, set by return and ei, cleared by di
// [RQ6] global on low blocks every source except the top interrupt
// [RQ7] software writes global on only with nothing pending, after di
// [RQ8] arbitration bit changes only by software write: 0 concurrent, 1 nested
// [RQ9] priority field 000 highest, 111 lowest, written by hardware or software
// [RQ10] priority decides pend or preempt; preempted level saved in level store
// [RQ11] flags reset to 00h, pushed on entry, restored on return, seven deep
// [RQ12] carry from bit 7 or 15; set, clear, complement instructions
// [RQ13] zero flag set when result is zero
// [RQ14] sign flag copies bit 7 or bit 15 of the result
// [RQ15] overflow set on two's-complement range error
// [RQ16] bcd kind flag records add or subtract for decimal adjust
// [RQ17] half carry captures carry out of or borrow into bit 3
// [RQ18] flag bit 1 kept 0; area flag set by sdm, cleared by spm
// [RQ19] register file seen as 32 blocks of eight; one or two windows
// [RQ20] srp selects single mode; set_twin_window_low and set_twin_window_high select twin mode and their block
// [RQ21] single mode rounds odd block down to even
// [RQ22] twin mode: r0-r7 via low pointer, r8-r15 via high pointer
// [RQ23] pointer holds block in 7:3, mode bit 2, bits 1:0 zero
// [RQ24] file address is block times eight plus offset in block
module sysreg_core
  import sysreg_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire cpu_cmd_t CMD,
  input wire alu_update_t ALU,
  input wire logic TOP_IRQ_REQ,
  input wire logic [7:0] IRQ_REQ,
  input wire logic [2:0] IRQ_REQ_LEVEL,
  input wire logic TOP_IRQ_NONMASK_BIT,
  input wire logic [3:0] TIMER_COUNT_ENABLE,
  input wire logic [3:0] WORK_REG,
  output logic [3:0] TIMER_RUN,
  output logic TOP_IRQ_TAKE,
  output logic IRQ_TAKE,
  output logic [7:0] FILE_ADDR,
  output logic [7:0] CENTRAL_IRQ_CONTROL,
  output logic [7:0] CPU_STATUS_FLAGS,
  output logic MEMORY_AREA_SELECT
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cic;
    logic [7:0] flags;
    logic [7:0] ptr_low;
    logic [7:0] ptr_high;
    logic [2:0] level_store;
    logic [FLAG_STACK_DEPTH-1:0][7:0] flag_stack;
    logic [2:0] stack_cnt;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st;
  state_t next_st;

  localparam state_t ST_RESET = '{
    cic: RST_CENTRAL_IRQ_CONTROL,
    flags: RST_CPU_STATUS_FLAGS,
    ptr_low: RST_WORK_POINTER,
    ptr_high: RST_WORK_POINTER,
    level_store: RST_NESTED_LEVEL_STORE[2:0],
    default: '0
  };

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_lane0;
  logic glob_on;
  logic top_pend;
  logic lower_ok;
  logic [15:0] res;
  logic res_zero;
  logic res_sign;
  logic single_mode;
  logic [4:0] block_sel;
  logic [7:0] ptr_wr;

  assign AWREADY = !st.aw_held && !st.bvalid;
  assign WREADY = !st.w_held && !st.bvalid;
  assign ARREADY = !st.rvalid;
  assign aw_fire = AWVALID && AWREADY;
  assign w_fire = WVALID && WREADY;
  assign ar_fire = ARVALID && ARREADY;
  assign wr_addr = st.aw_held ? st.aw_addr : AWADDR;
  assign wr_data = st.w_held ? st.w_data : WDATA;
  assign wr_lane0 = st.w_held ? st.w_strb[0] : WSTRB[0];
  assign do_write = (st.aw_held || aw_fire) && (st.w_held || w_fire);

  assign glob_on = st.cic[CIC_GLOBAL_ON];
  assign top_pend = st.cic[CIC_TOP_PEND];
  // ack only when the mask allows it; mask select adds global on to the condition
  assign TOP_IRQ_TAKE = top_pend && TOP_IRQ_NONMASK_BIT
                        && (!st.cic[CIC_TOP_SEL] || glob_on); // [RQ4]
  // strictly higher priority (lower code) than the running level
  assign lower_ok = IRQ_REQ_LEVEL < st.cic[2:0]; // [RQ9] [RQ10]
  assign IRQ_TAKE = (|IRQ_REQ) && glob_on && lower_ok && !TOP_IRQ_TAKE; // [RQ6]
  assign TIMER_RUN = TIMER_COUNT_ENABLE & {4{st.cic[CIC_GATE]}}; // [RQ2]

  assign res = ALU.word ? ALU.result : {8'h00, ALU.result[7:0]};
  assign res_zero = (res == 16'h0000); // [RQ13]
  assign res_sign = ALU.word ? ALU.result[15] : ALU.result[7]; // [RQ14]

  // working-register address
  assign single_mode = !st.ptr_low[PTR_MODE];
  always_comb begin
    if (single_mode) begin
      block_sel = {st.ptr_low[7:4], WORK_REG[3]}; // [RQ21] [RQ19]
    end else if (WORK_REG[3]) begin
      block_sel = st.ptr_high[7:3]; // [RQ22]
    end else begin
      block_sel = st.ptr_low[7:3]; // [RQ22]
    end
  end
  assign FILE_ADDR = {block_sel, WORK_REG[2:0]}; // [RQ24]

  assign CENTRAL_IRQ_CONTROL = st.cic;
  assign CPU_STATUS_FLAGS = st.flags;
  assign MEMORY_AREA_SELECT = st.flags[FLG_AREA]; // [RQ18]
  assign ptr_wr = {wr_data[7:3], wr_data[2], 2'b00}; // [RQ23]

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // bus channel capture
    if (aw_fire && !do_write) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = AWADDR;
    end
    if (w_fire && !do_write) begin
      next_st.w_held = 1'b1;
      next_st.w_data = WDATA;
      next_st.w_strb = WSTRB;
    end
    if (st.bvalid && BREADY) begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && RREADY) begin
      next_st.rvalid = 1'b0;
    end

    // software writes; hardware events below override them
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'b00;
      if (wr_addr == ADDR_CENTRAL_IRQ_CONTROL) begin
        if (wr_lane0) begin
          // software may set but the pending bit clears only by ack
          next_st.cic = wr_data[7:0];
          next_st.cic[CIC_TOP_PEND] = top_pend || wr_data[CIC_TOP_PEND]; // [RQ3]
          next_st.cic[CIC_ARB] = wr_data[CIC_ARB]; // [RQ8]
          // relies on software having disabled interrupts first
          next_st.cic[CIC_GLOBAL_ON] = wr_data[CIC_GLOBAL_ON]; // [RQ7]
        end
      end else if (wr_addr == ADDR_CPU_STATUS_FLAGS) begin
        if (wr_lane0) begin
          next_st.flags = wr_data[7:0];
          next_st.flags[FLG_RSVD] = 1'b0; // [RQ18]
        end
      end else if (wr_addr == ADDR_WORK_POINTER_LOW) begin
        if (wr_lane0) begin
          next_st.ptr_low = ptr_wr; // [RQ23]
        end
      end else if (wr_addr == ADDR_WORK_POINTER_HIGH) begin
        if (wr_lane0) begin
          next_st.ptr_high = ptr_wr; // [RQ23]
        end
      end else if (wr_addr == ADDR_NESTED_LEVEL_STORE) begin
        if (wr_lane0) begin
          next_st.level_store = wr_data[2:0];
        end
      end else begin
        next_st.bresp = 2'b10;
      end
    end

    // reads
    if (ar_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'b00;
      case (ARADDR)
        ADDR_CENTRAL_IRQ_CONTROL: next_st.rdata = {24'h0000_00, st.cic};
        ADDR_CPU_STATUS_FLAGS: next_st.rdata = {24'h0000_00, st.flags};
        ADDR_WORK_POINTER_LOW: next_st.rdata = {24'h0000_00, st.ptr_low};
        ADDR_WORK_POINTER_HIGH: next_st.rdata = {24'h0000_00, st.ptr_high};
        ADDR_NESTED_LEVEL_STORE: next_st.rdata = {29'h0000_0000, st.level_store};
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = 2'b10;
        end
      endcase
    end

    // hardware request sets the pending bit; set beats any clear
    if (TOP_IRQ_REQ) begin
      next_st.cic[CIC_TOP_PEND] = 1'b1; // [RQ3]
    end

    // interrupt-enable instructions
    if (CMD.ei || CMD.irq_return) begin
      next_st.cic[CIC_GLOBAL_ON] = 1'b1; // [RQ5]
    end
    if (CMD.di) begin
      next_st.cic[CIC_GLOBAL_ON] = 1'b0; // [RQ5]
    end

    // interrupt entry: save level and flags, clear global on
    if (CMD.irq_ack) begin
      next_st.cic[CIC_GLOBAL_ON] = 1'b0; // [RQ5]
      next_st.level_store = st.cic[2:0]; // [RQ10]
      next_st.cic[2:0] = CMD.ack_level; // [RQ9]
      if (TOP_IRQ_TAKE && !TOP_IRQ_REQ) begin
        next_st.cic[CIC_TOP_PEND] = 1'b0;
      end
      // beyond seven levels the newest copy is not saved
      if (st.stack_cnt < 3'(FLAG_STACK_DEPTH)) begin
        next_st.flag_stack[st.stack_cnt] = st.flags; // [RQ11]
        next_st.stack_cnt = st.stack_cnt + 3'd1;
      end
    end else if (CMD.irq_return) begin
      next_st.cic[2:0] = st.level_store; // [RQ10]
      if (st.stack_cnt != 3'd0) begin
        next_st.flags = st.flag_stack[st.stack_cnt - 3'd1]; // [RQ11]
        next_st.stack_cnt = st.stack_cnt - 3'd1;
      end
    end

    // alu results
    if (ALU.valid && !CMD.irq_return) begin
      next_st.flags[FLG_CARRY] = ALU.carry; // [RQ12]
      next_st.flags[FLG_ZERO] = res_zero; // [RQ13]
      next_st.flags[FLG_SIGN] = res_sign; // [RQ14]
      next_st.flags[FLG_OVF] = ALU.overflow; // [RQ15]
      if (ALU.bcd_kind) begin
        next_st.flags[FLG_BCD] = ALU.is_sub; // [RQ16]
        next_st.flags[FLG_HALF] = ALU.half; // [RQ17]
      end
    end

    // carry instructions
    if (CMD.scf) begin
      next_st.flags[FLG_CARRY] = 1'b1; // [RQ12]
    end else if (CMD.rcf) begin
      next_st.flags[FLG_CARRY] = 1'b0; // [RQ12]
    end else if (CMD.ccf) begin
      next_st.flags[FLG_CARRY] = !st.flags[FLG_CARRY]; // [RQ12]
    end

    // memory area
    if (CMD.sdm) begin
      next_st.flags[FLG_AREA] = 1'b1; // [RQ18]
    end else if (CMD.spm) begin
      next_st.flags[FLG_AREA] = 1'b0; // [RQ18]
    end
    next_st.flags[FLG_RSVD] = 1'b0; // [RQ18]

    // set-pointer instructions
    if (CMD.srp) begin
      next_st.ptr_low = {CMD.block, 3'b000}; // [RQ20]
      next_st.ptr_high[PTR_MODE] = 1'b0;
    end
    if (CMD.set_twin_window_low) begin
      next_st.ptr_low = {CMD.block, 3'b100}; // [RQ20]
      next_st.ptr_high[PTR_MODE] = 1'b1;
    end
    if (CMD.set_twin_window_high) begin
      next_st.ptr_high = {CMD.block, 3'b100}; // [RQ20]
      next_st.ptr_low[PTR_MODE] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= ST_RESET; // [RQ1] [RQ11]
    end else begin
      st <= next_st;
    end
  end

  assign BVALID = st.bvalid;
  assign BRESP = st.bresp;
  assign RVALID = st.rvalid;
  assign RDATA = st.rdata;
  assign RRESP = st.rresp;

endmodule : sysreg_core

// File: dv/sysreg_core_assertions.sv
// checker: port-level assertions for the system register block
`timescale 1ns/1ns
module sysreg_chk
  import sysreg_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire cpu_cmd_t CMD,
  input wire alu_update_t ALU,
  input wire logic TOP_IRQ_REQ,
  input wire logic TOP_IRQ_NONMASK_BIT,
  input wire logic [3:0] TIMER_COUNT_ENABLE,
  input wire logic [7:0] IRQ_REQ,
  input wire logic [2:0] IRQ_REQ_LEVEL,
  input wire logic BVALID,
  input wire logic [3:0] TIMER_RUN,
  input wire logic TOP_IRQ_TAKE,
  input wire logic IRQ_TAKE,
  input wire logic [7:0] CENTRAL_IRQ_CONTROL,
  input wire logic [7:0] CPU_STATUS_FLAGS,
  input wire logic MEMORY_AREA_SELECT
);
  logic [7:0] c;
  logic [7:0] f;
  assign c = CENTRAL_IRQ_CONTROL;
  assign f = CPU_STATUS_FLAGS;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_timer_gate: assert property (TIMER_RUN == (TIMER_COUNT_ENABLE & {4{c[7]}}))
    else $error("timer run wrong");
  chk_top_take: assert property (TOP_IRQ_TAKE == (c[6] && TOP_IRQ_NONMASK_BIT && (!c[5] || c[4])))
    else $error("top take wrong");
  chk_irq_block: assert property (IRQ_TAKE == (|IRQ_REQ && c[4] && IRQ_REQ_LEVEL < c[2:0] && !TOP_IRQ_TAKE))
    else $error("irq take wrong");
  chk_ack_clears: assert property (CMD.irq_ack && !CMD.ei && !CMD.irq_return |=> !c[4])
    else $error("ack left enable on");
  chk_enable_sets: assert property ((CMD.ei || CMD.irq_return) && !CMD.irq_ack && !CMD.di |=> c[4])
    else $error("enable not set");
  chk_top_pend: assert property (TOP_IRQ_REQ && !CMD.irq_ack |=> c[6])
    else $error("top pending not set");
  chk_arb_write: assert property ($changed(c[3]) |-> $rose(BVALID))
    else $error("arbitration bit moved without write");
  chk_rsvd_flag: assert property (!f[1] && MEMORY_AREA_SELECT == f[0])
    else $error("flag bit 1 or area wrong");
  chk_area_sdm: assert property (CMD.sdm && !CMD.spm && !CMD.irq_return |=> MEMORY_AREA_SELECT)
    else $error("sdm did not set area");
  chk_zero_flag: assert property (ALU.valid && !CMD.irq_return |=>
    f[6] == ($past(ALU.word) ? $past(ALU.result) == 16'h0000 : $past(ALU.result[7:0]) == 8'h00))
    else $error("zero flag wrong");
  chk_sign_copy: assert property (ALU.valid && !CMD.irq_return |=>
    f[5] == ($past(ALU.word) ? $past(ALU.result[15]) : $past(ALU.result[7])))
    else $error("sign flag wrong");
  chk_carry_cpl: assert property (CMD.ccf && !CMD.scf && !CMD.rcf && !CMD.irq_return && !ALU.valid |=>
    f[7] != $past(f[7]))
    else $error("ccf did not flip carry");
  cover property (CMD.irq_ack && TOP_IRQ_TAKE);
  cover property (CMD.irq_ack && IRQ_TAKE);
  cover property ($rose(BVALID));
endmodule : sysreg_chk

bind sysreg_core sysreg_chk u_chk (.CLK(CLK), .RST_N(RST_N), .CMD(CMD), .ALU(ALU), .TOP_IRQ_REQ(TOP_IRQ_REQ),
  .TOP_IRQ_NONMASK_BIT(TOP_IRQ_NONMASK_BIT), .TIMER_COUNT_ENABLE(TIMER_COUNT_ENABLE), .IRQ_REQ(IRQ_REQ),
  .IRQ_REQ_LEVEL(IRQ_REQ_LEVEL), .BVALID(BVALID), .TIMER_RUN(TIMER_RUN), .TOP_IRQ_TAKE(TOP_IRQ_TAKE),
  .IRQ_TAKE(IRQ_TAKE), .CENTRAL_IRQ_CONTROL(CENTRAL_IRQ_CONTROL), .CPU_STATUS_FLAGS(CPU_STATUS_FLAGS),
  .MEMORY_AREA_SELECT(MEMORY_AREA_SELECT));

// File: dv/exec_unit_model.sv
// partner: execution unit that acknowledges granted interrupts
`timescale 1ns/1ns
module exec_unit_model
  import sysreg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic take,
  input wire logic ack_on,
  input wire logic [2:0] ack_lvl,
  input wire cpu_cmd_t cmd_in,
  output cpu_cmd_t cmd_out
);
  logic ack_q;
  // one pulse per grant: take still shows high in the cycle of the pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ack_q <= 1'b0;
    else ack_q <= ack_on && take && !ack_q;
  end
  always_comb begin
    cmd_out = cmd_in;
    cmd_out.irq_ack = cmd_in.irq_ack | ack_q;
    if (ack_q) cmd_out.ack_level = ack_lvl;
  end
endmodule : exec_unit_model

// File: dv/cpu_system_regs_irq_flags_ptrs_test.sv
// testbench: scenario tasks for the system register block
`timescale 1ns/1ns
module cpu_system_regs_irq_flags_ptrs_test;
  import sysreg_pkg::*;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic top_req, nonmask, top_take, irq_take, area, ack_on;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [7:0] irq_req, file_addr, cic, flags;
  logic [3:0] tmr_en, tmr_run, work_reg, wstrb;
  logic [2:0] irq_lvl, ack_lvl;
  cpu_cmd_t cmd_in, cmd;
  alu_update_t alu;
  int n_mismatch, compares;
  sysreg_core DUT (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .CMD(cmd), .ALU(alu), .TOP_IRQ_REQ(top_req), .IRQ_REQ(irq_req),
    .IRQ_REQ_LEVEL(irq_lvl), .TOP_IRQ_NONMASK_BIT(nonmask), .TIMER_COUNT_ENABLE(tmr_en), .WORK_REG(work_reg),
    .TIMER_RUN(tmr_run), .TOP_IRQ_TAKE(top_take), .IRQ_TAKE(irq_take), .FILE_ADDR(file_addr),
    .CENTRAL_IRQ_CONTROL(cic), .CPU_STATUS_FLAGS(flags), .MEMORY_AREA_SELECT(area));
  exec_unit_model u_exec (.clk(clk), .rst_n(rst_n), .take(irq_take | top_take), .ack_on(ack_on),
    .ack_lvl(ack_lvl), .cmd_in(cmd_in), .cmd_out(cmd));
  // ------
  // helpers
  // ------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    bit ad, wd, ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      ta = !ad && awready;
      tw = !wd && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      ad = ad | ta;
      wd = wd | tw;
    end
    while (!tb) begin
      @(negedge clk);
      tb = bvalid;
      r = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    bit t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(negedge clk);
      t = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask : rd
  task automatic do_cmd(input cpu_cmd_t c);
    @(posedge clk);
    cmd_in <= c;
    @(posedge clk);
    cmd_in <= '0;
    @(negedge clk);
  endtask : do_cmd
  task automatic alu_op(input alu_update_t a);
    @(posedge clk);
    alu <= a;
    @(posedge clk);
    alu <= '0;
    @(negedge clk);
  endtask : alu_op
  task automatic fa(input logic [3:0] w, input logic [7:0] e);
    @(posedge clk);
    work_reg <= w;
    @(negedge clk);
    chk(32'(file_addr), 32'(e));
  endtask : fa
  task automatic wait_bit(input int b, input logic v);
    for (int i = 0; i < 10 && cic[b] !== v; i++) @(negedge clk);
    if (cic[b] !== v) n_mismatch++;
  endtask : wait_bit
  // ------
  // scenarios
  // ------
  task automatic t_reset();
    rd(ADDR_CENTRAL_IRQ_CONTROL);
    chk(d, 32'h0000_0087);
    rd(ADDR_CPU_STATUS_FLAGS);
    chk(d, 32'h0000_0000);
    rd(ADDR_WORK_POINTER_LOW);
    chk(d, 32'h0000_0000);
    rd(10'h004);
    chk(32'(r), 32'h0000_0002);
    wr(10'h004, 8'hff);
    chk(32'(r), 32'h0000_0002);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_ptr();
    do_cmd('{srp: 1'b1, block: 5'h03, default: '0});
    fa(4'h0, 8'h10);
    fa(4'hf, 8'h1f);
    rd(ADDR_WORK_POINTER_LOW);
    chk(d, 32'h0000_0018);
    do_cmd('{set_twin_window_low: 1'b1, block: 5'h05, default: '0});
    do_cmd('{set_twin_window_high: 1'b1, block: 5'h09, default: '0});
    fa(4'h2, 8'h2a);
    fa(4'ha, 8'h4a);
    rd(ADDR_WORK_POINTER_LOW);
    chk(d, 32'h0000_002c);
    rd(ADDR_WORK_POINTER_HIGH);
    chk(d, 32'h0000_004c);
    wr(ADDR_WORK_POINTER_LOW, 8'hff);
    rd(ADDR_WORK_POINTER_LOW);
    chk(d, 32'h0000_00fc);
    // lane 0 off: the write must leave the pointer alone
    wstrb <= 4'h0;
    wr(ADDR_WORK_POINTER_HIGH, 8'h00);
    @(posedge clk);
    wstrb <= 4'h1;
    rd(ADDR_WORK_POINTER_HIGH);
    chk(d, 32'h0000_004c);
    $display("t_ptr done");
  endtask : t_ptr
  task automatic t_flags();
    alu_op('{valid: 1'b1, result: 16'h0080, carry: 1'b1, half: 1'b1, overflow: 1'b1, is_sub: 1'b1,
      bcd_kind: 1'b1, default: '0});
    chk(32'(flags), 32'h0000_00bc);
    alu_op('{valid: 1'b1, word: 1'b1, default: '0});
    chk(32'(flags), 32'h0000_004c);
    alu_op('{valid: 1'b1, result: 16'h8100, carry: 1'b1, bcd_kind: 1'b1, default: '0});
    chk(32'(flags), 32'h0000_00c0);
    do_cmd('{ccf: 1'b1, default: '0});
    chk(32'(flags), 32'h0000_0040);
    do_cmd('{scf: 1'b1, default: '0});
    chk(32'(flags), 32'h0000_00c0);
    do_cmd('{rcf: 1'b1, default: '0});
    do_cmd('{sdm: 1'b1, default: '0});
    chk(32'(flags), 32'h0000_0041);
    do_cmd('{spm: 1'b1, default: '0});
    chk(32'(area), 32'h0000_0000);
    alu_op('{valid: 1'b1, word: 1'b1, result: 16'h8000, carry: 1'b1, default: '0});
    chk(32'(flags), 32'h0000_00a0);
    wr(ADDR_CPU_STATUS_FLAGS, 8'hff);
    rd(ADDR_CPU_STATUS_FLAGS);
    chk(d, 32'h0000_00fd);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_timer();
    @(posedge clk);
    tmr_en <= 4'ha;
    @(negedge clk);
    chk(32'(tmr_run), 32'h0000_000a);
    do_cmd('{di: 1'b1, default: '0});
    wr(ADDR_CENTRAL_IRQ_CONTROL, 8'h07);
    chk(32'(tmr_run), 32'h0000_0000);
    wr(ADDR_CENTRAL_IRQ_CONTROL, 8'h8f);
    rd(ADDR_CENTRAL_IRQ_CONTROL);
    chk(d, 32'h0000_008f);
    $display("t_timer done");
  endtask : t_timer
  task automatic t_irq();
    do_cmd('{ei: 1'b1, default: '0});
    @(posedge clk);
    irq_req <= 8'h01;
    irq_lvl <= 3'h7;
    @(negedge clk);
    chk(32'(irq_take), 32'h0000_0000);
    @(posedge clk);
    irq_lvl <= 3'h3;
    @(negedge clk);
    chk(32'(irq_take), 32'h0000_0001);
    do_cmd('{di: 1'b1, default: '0});
    chk(32'(irq_take), 32'h0000_0000);
    do_cmd('{ei: 1'b1, default: '0});
    @(posedge clk);
    ack_lvl <= 3'h3;
    ack_on <= 1'b1;
    wait_bit(4, 1'b0);
    @(posedge clk);
    irq_req <= 8'h00;
    ack_on <= 1'b0;
    @(negedge clk);
    chk(32'(cic[4:0]), 32'h0000_000b);
    rd(ADDR_NESTED_LEVEL_STORE);
    chk(d, 32'h0000_0007);
    do_cmd('{rcf: 1'b1, default: '0});
    chk(32'(flags), 32'h0000_007d);
    do_cmd('{irq_return: 1'b1, default: '0});
    chk(32'(flags), 32'h0000_00fd);
    chk(32'(cic[4:0]), 32'h0000_001f);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_top();
    do_cmd('{di: 1'b1, default: '0});
    @(posedge clk);
    nonmask <= 1'b1;
    wr(ADDR_CENTRAL_IRQ_CONTROL, 8'hc7);
    chk(32'(top_take), 32'h0000_0001);
    wr(ADDR_CENTRAL_IRQ_CONTROL, 8'he7);
    chk(32'(top_take), 32'h0000_0000);
    do_cmd('{ei: 1'b1, default: '0});
    chk(32'(top_take), 32'h0000_0001);
    @(posedge clk);
    ack_on <= 1'b1;
    wait_bit(6, 1'b0);
    @(posedge clk);
    ack_on <= 1'b0;
    nonmask <= 1'b0;
    @(negedge clk);
    chk(32'(cic[6:4]), 32'h0000_0002);
    @(posedge clk);
    top_req <= 1'b1;
    @(posedge clk);
    top_req <= 1'b0;
    @(negedge clk);
    chk(32'(cic[6]), 32'h0000_0001);
    $display("t_top done");
  endtask : t_top
  task automatic t_rerst();
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(32'(cic), 32'h0000_0087);
    chk(32'(flags), 32'h0000_0000);
    $display("t_rerst done");
  endtask : t_rerst
  // ------
  // run
  // ------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, top_req, nonmask, ack_on} = '0;
    {awaddr, araddr, wdata, irq_req, tmr_en, work_reg, irq_lvl, ack_lvl} = '0;
    cmd_in = '0;
    alu = '0;
    wstrb = 4'h1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_ptr();
    t_flags();
    t_timer();
    t_irq();
    t_top();
    t_rerst();
    finish_test();
  end
endmodule : cpu_system_regs_irq_flags_ptrs_test
